/* dii_top.v */
`include "dii_regs.vh"
`default_nettype none
module dii_top
#(
  parameter STRETCH_CYC = `DII_STRETCH_CYC,
  parameter [15:0] IND_DATA_MASK = 16'hFFFF
)
(
  input wire i_clock,
  input wire i_reset_n,
  input wire i_enable,
  input wire i_scl,
  input wire i_sda,
  output reg o_scl_oe,
  output reg o_sda_oe,
  output reg o_scl_out,
  output reg o_sda_out,
  input wire i_fast_blank_input_pin,
  input wire i_blank_input_slope,
  output reg [7:0] o_output_pin_drive_config,
  output reg [7:0] o_output_pin_drive_config_two,
  output reg o_sync_fifo_tristate,
  output reg o_flyback_active_low,
  output reg o_east_west_pulse_enable,
  output reg o_ctl_req,
  output reg o_ctl_write,
  output reg [15:0] o_ctl_addr,
  output reg [15:0] o_ctl_wdata,
  input wire i_ctl_ack,
  input wire [15:0] i_ctl_rdata,
  output reg o_ctl_timeout,
  output reg o_init_busy
);
  // ************************************
  // pin synchronisers
  // ************************************
  wire scl_s;
  wire sda_s;
  wire fb_s;
  wire slope_s;
  dii_sync u_scl (.i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_enable(i_enable), .i_async(i_scl), .o_sync(scl_s));
  dii_sync u_sda (.i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_enable(i_enable), .i_async(i_sda), .o_sync(sda_s));
  dii_sync u_fb (.i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_enable(i_enable), .i_async(i_fast_blank_input_pin),
    .o_sync(fb_s));
  dii_sync u_slp (.i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_enable(i_enable), .i_async(i_blank_input_slope),
    .o_sync(slope_s));

  // ************************************
  // bus state
  // ************************************
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_RX = 3'h1;
  localparam [2:0] ST_ACK = 3'h2;
  localparam [2:0] ST_TX = 3'h3;
  localparam [2:0] ST_TXACK = 3'h4;
  localparam [2:0] ST_WAIT = 3'h5;
  localparam [2:0] ST_SKIP = 3'h6;

  reg [2:0] state;
  reg scl_d;
  reg sda_d;
  reg [7:0] shift;
  reg [3:0] bit_cnt;
  reg [2:0] byte_idx;
  reg [7:0] subaddr;
  reg is_read;
  reg [15:0] rdata;
  reg rd_valid;
  reg stretch;
  reg [31:0] wait_cnt;
  reg [7:0] pin_cfg;
  reg [7:0] pin_cfg2;
  reg init_pend;
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_c = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_c = scl_s & scl_d & ~sda_d & sda_s;
  function [7:0] tx_byte;
    input [7:0] sub;
    input [2:0] idx;
    input [15:0] ind;
    input [7:0] cfg;
    input [7:0] cfg2;
    input [1:0] fb;
    begin
      case (sub)
        `DII_SUB_PIN_CFG: tx_byte = cfg;
        `DII_SUB_PIN_CFG2: tx_byte = cfg2;
        `DII_SUB_FB_STATUS: tx_byte = {6'h00, fb};
        `DII_SUB_IND_READ: tx_byte = idx[0] ? ind[7:0] : ind[15:8];
        default: tx_byte = 8'h00;
      endcase
    end
  endfunction
  wire [1:0] fb_bits = {slope_s, fb_s};
  wire [7:0] rx_byte = shift;
  wire busy_ind = (subaddr == `DII_SUB_IND_READ) && !rd_valid;
  wire [7:0] tx_now = tx_byte(subaddr, byte_idx, rdata, pin_cfg, pin_cfg2,
    fb_bits);
  always @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state <= ST_IDLE;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      shift <= 8'h00;
      bit_cnt <= 4'h0;
      byte_idx <= 3'h0;
      subaddr <= 8'h00;
      is_read <= 1'b0;
      rdata <= 16'h0000;
      rd_valid <= 1'b0;
      stretch <= 1'b0;
      wait_cnt <= 32'h0;
      pin_cfg <= 8'h00;
      pin_cfg2 <= 8'h00;
      init_pend <= 1'b1;
      o_sda_oe <= 1'b0;
      o_ctl_req <= 1'b0;
      o_ctl_write <= 1'b0;
      o_ctl_addr <= 16'h0000;
      o_ctl_wdata <= 16'h0000;
      o_ctl_timeout <= 1'b0;
    end
    else if (i_enable)
    begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      if (init_pend)
      begin
        // defaults load on the first enabled cycle after reset release
        pin_cfg <= `DII_PIN_CFG_RESET;
        pin_cfg2 <= `DII_PIN_CFG2_RESET;
        init_pend <= 1'b0;
      end
      // controller handshake with stretch timeout
      if (o_ctl_req)
      begin
        if (i_ctl_ack)
        begin
          o_ctl_req <= 1'b0;
          stretch <= 1'b0;
          if (!o_ctl_write)
          begin
            rdata <= i_ctl_rdata & IND_DATA_MASK;
            rd_valid <= 1'b1;
          end
        end
        else if (wait_cnt >= STRETCH_CYC - 1)
        begin
          // give up rather than hold the bus forever
          o_ctl_req <= 1'b0;
          stretch <= 1'b0;
          o_ctl_timeout <= 1'b1;
          rdata <= 16'h0000;
          rd_valid <= 1'b1;
        end
        else
          wait_cnt <= wait_cnt + 32'h1;
      end
      if (start_c)
      begin
        state <= ST_RX;
        bit_cnt <= 4'h0;
        byte_idx <= 3'h0;
        o_sda_oe <= 1'b0;
      end
      else if (stop_c)
      begin
        state <= ST_IDLE;
        o_sda_oe <= 1'b0;
      end
      else
      begin
        case (state)
          ST_IDLE, ST_SKIP:
            o_sda_oe <= 1'b0;
          ST_RX:
            if (scl_rise)
            begin
              shift <= {shift[6:0], sda_s};
              bit_cnt <= bit_cnt + 4'h1;
            end
            else if (scl_fall && bit_cnt == 4'h8)
            begin
              bit_cnt <= 4'h0;
              if (byte_idx == 3'h0)
              begin
                if (rx_byte[7:1] == `DII_DEV_ADDR)
                begin
                  is_read <= rx_byte[0];
                  o_sda_oe <= 1'b1;
                  state <= ST_ACK;
                  byte_idx <= {2'h0, ~rx_byte[0]};
                end
                else
                  state <= ST_SKIP;
              end
              else
              begin
                o_sda_oe <= 1'b1;
                state <= ST_ACK;
                case (byte_idx)
                  3'h1:
                  begin
                    subaddr <= rx_byte;
                    if (rx_byte == `DII_SUB_IND_READ)
                      rd_valid <= 1'b0;
                  end
                  3'h2:
                    case (subaddr)
                      `DII_SUB_PIN_CFG: pin_cfg <= rx_byte;
                      `DII_SUB_PIN_CFG2:
                        pin_cfg2 <= rx_byte & `DII_PIN_CFG2_MASK;
                      `DII_SUB_IND_WRITE, `DII_SUB_IND_READ:
                        o_ctl_addr[15:8] <= rx_byte;
                      default: ;
                    endcase
                  3'h3:
                  begin
                    o_ctl_addr[7:0] <= rx_byte;
                    if (subaddr == `DII_SUB_IND_READ)
                    begin
                      o_ctl_req <= 1'b1;
                      o_ctl_write <= 1'b0;
                      wait_cnt <= 32'h0;
                    end
                  end
                  3'h4:
                    o_ctl_wdata[15:8] <= rx_byte;
                  3'h5:
                    if (subaddr == `DII_SUB_IND_WRITE)
                    begin
                      o_ctl_wdata[7:0] <= rx_byte;
                      o_ctl_req <= 1'b1;
                      o_ctl_write <= 1'b1;
                      wait_cnt <= 32'h0;
                      stretch <= 1'b1;
                    end
                  default: ;
                endcase
                if (byte_idx != 3'h7)
                  byte_idx <= byte_idx + 3'h1;
              end
            end
          ST_ACK:
            if (scl_fall)
            begin
              o_sda_oe <= 1'b0;
              if (is_read && busy_ind)
              begin
                stretch <= 1'b1;
                state <= ST_WAIT;
              end
              else if (is_read)
              begin
                shift <= tx_now;
                o_sda_oe <= ~tx_now[7];
                state <= ST_TX;
              end
              else
                state <= ST_RX;
            end
          ST_WAIT:
            if (rd_valid)
            begin
              stretch <= 1'b0;
              shift <= tx_now;
              o_sda_oe <= ~tx_now[7];
              state <= ST_TX;
            end
          ST_TX:
            if (scl_fall)
            begin
              if (bit_cnt == 4'h7)
              begin
                bit_cnt <= 4'h0;
                o_sda_oe <= 1'b0;
                state <= ST_TXACK;
              end
              else
              begin
                bit_cnt <= bit_cnt + 4'h1;
                shift <= {shift[6:0], 1'b0};
                o_sda_oe <= ~shift[6];
              end
            end
          ST_TXACK:
            if (scl_rise)
            begin
              if (sda_s)
                state <= ST_SKIP;
              else
                byte_idx <= byte_idx + 3'h1;
            end
            else if (scl_fall)
            begin
              shift <= tx_now;
              o_sda_oe <= ~tx_now[7];
              state <= ST_TX;
            end
          default:
            state <= ST_IDLE;
        endcase
      end
    end
  end

  // ************************************
  // registered outputs
  // ************************************
  always @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_scl_oe <= 1'b0;
      o_scl_out <= 1'b0;
      o_sda_out <= 1'b0;
      o_output_pin_drive_config <= 8'h00;
      o_output_pin_drive_config_two <= 8'h00;
      o_sync_fifo_tristate <= 1'b0;
      o_flyback_active_low <= 1'b0;
      o_east_west_pulse_enable <= 1'b0;
      o_init_busy <= 1'b1;
    end
    else if (i_enable)
    begin
      // write stalls release on the controller answer or on the stretch timeout
      o_scl_oe <= stretch;
      o_scl_out <= 1'b0;
      o_sda_out <= 1'b0;
      o_output_pin_drive_config <= pin_cfg;
      o_output_pin_drive_config_two <= pin_cfg2;
      o_sync_fifo_tristate <=
        pin_cfg[`DII_SYNC_LO+1:`DII_SYNC_LO] == 2'h3;
      o_flyback_active_low <= pin_cfg[`DII_FLYBACK_INPUT_POLARITY_BIT];
      o_east_west_pulse_enable <= pin_cfg[`DII_EW_PWM_BIT];
      o_init_busy <= init_pend;
    end
  end
endmodule
`default_nettype wire

/* dii_regs.vh */
`ifndef DII_REGS_VH
`define DII_REGS_VH
`define DII_DEV_ADDR 7'h45
`define DII_SUB_PIN_CFG 8'h10
`define DII_SUB_PIN_CFG2 8'h15
`define DII_SUB_FB_STATUS 8'h1E
`define DII_SUB_IND_WRITE 8'h12
`define DII_SUB_IND_READ 8'h13
`define DII_PIN_CFG_RESET 8'h00
`define DII_PIN_CFG2_RESET 8'h00
`define DII_PIN_CFG2_MASK 8'h0F
`define DII_FB_LEVEL_BIT 0
`define DII_FB_SLOPE_BIT 1
`define DII_SYNC_LO 0
`define DII_PULSE1_BIT 2
`define DII_PULSE2_BIT 3
`define DII_VPULSE_BIT 4
`define DII_EW_PWM_BIT 5
`define DII_FLYBACK_INPUT_POLARITY_BIT 6
`define DII_VBL_BIT 7
`define DII_EW_LO 0
`define DII_HVS_LO 2
`define DII_STRETCH_MS 20
`define DII_CLK_KHZ 20000
`define DII_STRETCH_CYC (`DII_STRETCH_MS * `DII_CLK_KHZ)
`endif

/* dii_sync.v */
`default_nettype none
module dii_sync
(
  input wire i_clock,
  input wire i_reset_n,
  input wire i_enable,
  input wire i_async,
  output reg o_sync
);
  reg stage;
  always @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      stage <= 1'b1;
      o_sync <= 1'b1;
    end
    else if (i_enable)
    begin
      stage <= i_async;
      o_sync <= stage;
    end
  end
endmodule
`default_nettype wire

/* dii_chk.sv */
`default_nettype none
module dii_chk
#(
  parameter int STRETCH_CYC = 200
)
(
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic o_scl_oe,
  input wire logic o_scl_out,
  input wire logic o_sda_out,
  input wire logic [7:0] o_output_pin_drive_config,
  input wire logic [7:0] o_output_pin_drive_config_two,
  input wire logic o_sync_fifo_tristate,
  input wire logic o_flyback_active_low,
  input wire logic o_east_west_pulse_enable,
  input wire logic o_ctl_req,
  input wire logic o_ctl_timeout,
  input wire logic o_init_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic [7:0] cfg = o_output_pin_drive_config;
  logic req_d;
  int req_len;
  // ****
  // stretch length
  // ****
  // held after the request drops, so a late timeout flag is still judged
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      req_d <= 1'b0;
      req_len <= 0;
    end
    else
    begin
      req_d <= o_ctl_req;
      if (o_ctl_req)
        req_len <= req_d ? req_len + 1 : 1;
    end
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  sequence s_cfg_still; $stable(cfg) [*2]; endsequence
  sequence s_scl_free; ##[0:3] !o_scl_oe; endsequence
  sequence s_init_end; ##[1:4] !o_init_busy; endsequence
  property p_sync;
    s_cfg_still |-> o_sync_fifo_tristate == &cfg[1:0];
  endproperty
  a_sync: assert property (p_sync) else $error("bad tristate");
  property p_fly; s_cfg_still |-> o_flyback_active_low == cfg[6]; endproperty
  a_fly: assert property (p_fly) else $error("bad flyback");
  property p_ew; s_cfg_still |-> o_east_west_pulse_enable == cfg[5];
  endproperty
  a_ew: assert property (p_ew) else $error("bad ew enable");
  property p_cfg2; o_output_pin_drive_config_two[7:4] == 4'h0; endproperty
  a_cfg2: assert property (p_cfg2) else $error("cfg2 top set");
  property p_od; !o_scl_out && !o_sda_out; endproperty
  a_od: assert property (p_od) else $error("pin driven high");
  property p_hold;
    o_scl_oe |-> o_ctl_req || $past(o_ctl_req) || $past(o_ctl_req, 2);
  endproperty
  a_hold: assert property (p_hold) else $error("idle stretch");
  property p_rel; $fell(o_ctl_req) |-> s_scl_free; endproperty
  a_rel: assert property (p_rel) else $error("scl kept");
  property p_late; o_ctl_req |-> req_len <= STRETCH_CYC + 8; endproperty
  a_late: assert property (p_late) else $error("no timeout");
  property p_early;
    $rose(o_ctl_timeout) |-> req_len >= STRETCH_CYC - 4;
  endproperty
  a_early: assert property (p_early) else $error("early timeout");
  property p_rst;
    !$past(i_reset_n) |-> cfg == 8'h00 && !o_ctl_timeout &&
      o_output_pin_drive_config_two == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset");
  property p_init; o_init_busy |-> s_init_end; endproperty
  a_init: assert property (p_init) else $error("init hangs");
endmodule
bind dii_top dii_chk #(.STRETCH_CYC(STRETCH_CYC)) chk_u
(
  .i_clock, .i_reset_n, .o_scl_oe, .o_scl_out, .o_sda_out,
  .o_output_pin_drive_config, .o_output_pin_drive_config_two,
  .o_sync_fifo_tristate, .o_flyback_active_low, .o_east_west_pulse_enable,
  .o_ctl_req, .o_ctl_timeout, .o_init_busy
);
`default_nettype wire

/* dii_i2c_master.sv */
`default_nettype none
module dii_i2c_master
(
  input wire logic i_clock,
  input wire logic i_scl,
  input wire logic i_sda,
  output var logic o_scl_low,
  output var logic o_sda_low
);
  timeunit 1ns;
  timeprecision 1ns;
  int stretched = 0;
  initial
  begin
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
  end
  // ****
  // bus phases, 400 ns per bit
  // ****
  // wait out a held clock, then carry on where the bit stalled
  task rise();
    int n;
    n = 0;
    o_scl_low = 1'b0;
    @(negedge i_clock);
    while (i_scl !== 1'b1)
    begin
      n++;
      stretched++;
      if (n > 1000)
      begin
        dii_tb_top.n_errors++;
        dii_tb_top.report_and_stop();
      end
      @(negedge i_clock);
    end
  endtask
  task bit_io(input logic b, output logic r);
    o_sda_low = !b;
    #200;
    rise();
    #100 r = i_sda;
    #50 o_scl_low = 1'b1;
  endtask
  task start();
    o_sda_low = 1'b0;
    // let the target drop its acknowledge first, or this reads as a stop
    #200;
    rise();
    #150 o_sda_low = 1'b1;
    #200 o_scl_low = 1'b1;
  endtask
  task stop();
    o_sda_low = 1'b1;
    #100;
    rise();
    #150 o_sda_low = 1'b0;
    #200;
  endtask
  task wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // the last byte of a read is refused so the target lets go
  task rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
endmodule
`default_nettype wire

/* dii_tb_top.sv */
`default_nettype none
module dii_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int STRETCH = 200;
  localparam logic [15:0] IND_MASK = 16'h0FFF;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic en = 1'b1;
  logic fb_level = 1'b0;
  logic fb_slope = 1'b0;
  logic ctl_ack = 1'b0;
  logic [15:0] ctl_rdata = 16'h0000;
  wire logic scl_oe, sda_oe, scl_out, sda_out, m_scl_low, m_sda_low;
  wire logic scl = !(m_scl_low | (scl_oe & !scl_out));
  wire logic sda = !(m_sda_low | (sda_oe & !sda_out));
  wire logic [7:0] cfg, cfg2;
  wire logic tsf, fly, ew, req, wr_flag, tmo, busy;
  wire logic [15:0] addr, wdata;
  int n_errors = 0;
  int n_compared = 0;
  int ctl_delay = 10;
  int cnt = 0;
  logic done = 1'b0;
  logic got_wr, a;
  logic [15:0] got_addr, got_wdata, v;
  logic [7:0] sub, wr, ex, fb;
  logic [31:0] rows [11] = '{32'h10000000, 32'h10010100, 32'h10020200,
    32'h10030300, 32'h10646400, 32'h10989800, 32'h150F0F00, 32'h15060600,
    32'h1E020101, 32'h1E010202, 32'h1E000303};
  always #25 clk = !clk;
  dii_top #(.STRETCH_CYC(STRETCH), .IND_DATA_MASK(IND_MASK)) dut_u
  (
    .i_clock(clk), .i_reset_n(rst_n), .i_enable(en), .i_scl(scl),
    .i_sda(sda), .o_scl_oe(scl_oe), .o_sda_oe(sda_oe),
    .o_scl_out(scl_out), .o_sda_out(sda_out),
    .i_fast_blank_input_pin(fb_level), .i_blank_input_slope(fb_slope),
    .o_output_pin_drive_config(cfg), .o_output_pin_drive_config_two(cfg2),
    .o_sync_fifo_tristate(tsf), .o_flyback_active_low(fly),
    .o_east_west_pulse_enable(ew), .o_ctl_req(req), .o_ctl_write(wr_flag),
    .o_ctl_addr(addr), .o_ctl_wdata(wdata), .i_ctl_ack(ctl_ack),
    .i_ctl_rdata(ctl_rdata), .o_ctl_timeout(tmo), .o_init_busy(busy)
  );
  dii_i2c_master master_u
  (
    .i_clock(clk), .i_scl(scl), .i_sda(sda),
    .o_scl_low(m_scl_low), .o_sda_low(m_sda_low)
  );
  // ****
  // controller stand-in
  // ****
  always @(negedge clk)
  begin
    if (req !== 1'b1)
    begin
      ctl_ack <= 1'b0;
      cnt = 0;
      done = 1'b0;
    end
    else if (!done && ++cnt >= ctl_delay)
    begin
      ctl_ack <= 1'b1;
      done = 1'b1;
      {got_wr, got_addr, got_wdata} = {wr_flag, addr, wdata};
    end
    else
      ctl_ack <= 1'b0;
  end
  task chk(input logic [47:0] s, input logic [47:0] e);
    n_compared++;
    if (s !== e)
    begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task wb(input logic [7:0] d);
    logic ack;
    master_u.wbyte(d, ack);
    chk(ack, 1'b1);
  endtask
  // nw bytes written, then a repeated start and nr bytes read
  task xfer(input logic [47:0] w, input int nw, input int nr,
    output logic [15:0] d);
    logic [7:0] b;
    d = 16'h0000;
    master_u.start();
    for (int i = nw - 1; i >= 0; i--)
      wb(w[i * 8 +: 8]);
    if (nr > 0)
    begin
      master_u.start();
      wb(8'h8B);
      for (int i = nr - 1; i >= 0; i--)
      begin
        master_u.rbyte(i == 0, b);
        d = {d[7:0], b};
      end
    end
    master_u.stop();
  endtask
  task do_reset(input logic freeze);
    rst_n = 1'b0;
    en = !freeze;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    // a frozen block must not have run its start-up load yet
    chk(busy, freeze);
    en = 1'b1;
    repeat (6) @(negedge clk);
    $display("reset done");
  endtask
  task report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    do_reset(1'b0);
    foreach (rows[k])
    begin
      {sub, wr, ex, fb} = rows[k];
      {fb_slope, fb_level} = fb[1:0];
      xfer({8'h8A, sub, wr}, 3, 0, v);
      xfer({8'h8A, sub}, 2, 1, v);
      chk(v, ex);
      if (sub == 8'h10)
        chk({cfg, tsf, fly, ew}, {ex, &ex[1:0], ex[6:5]});
      if (sub == 8'h15)
        chk(cfg2, ex);
      $display("row %0d done", k);
    end
    master_u.start();
    master_u.wbyte(8'h88, a);
    chk(a, 1'b0);
    master_u.stop();
    $display("foreign address done");
    ctl_delay = 30;
    master_u.stretched = 0;
    xfer({8'h8A, 8'h12, 16'h0123, 16'h0ABC}, 6, 0, v);
    chk({got_wr, got_addr, got_wdata}, {1'b1, 32'h01230ABC});
    chk(master_u.stretched > 0, 1'b1);
    $display("indirect write done");
    ctl_delay = 150;
    ctl_rdata = 16'hF5A5;
    master_u.stretched = 0;
    xfer({8'h8A, 8'h13, 16'h0456}, 4, 2, v);
    chk({got_wr, got_addr}, {1'b0, 16'h0456});
    chk({master_u.stretched > 0, v}, {1'b1, 16'hF5A5 & IND_MASK});
    $display("indirect read done");
    ctl_delay = 1000;
    xfer({8'h8A, 8'h13, 16'h0456}, 4, 2, v);
    chk({tmo, v}, {1'b1, 16'h0000});
    $display("timeout done");
    do_reset(1'b1);
    chk({tmo, cfg, cfg2}, 17'h0);
    xfer({8'h8A, 8'h10}, 2, 1, v);
    chk(v, 16'h0000);
    $display("second reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire
